// *** p3g_assertions.sv ***
/*
 Checker on the register bus and peripheral lines between the two port ends.
 Assumes it is instantiated beside the interface, fed by name.
*/
`timescale 1ns/10ps
module p3g_assertions
   import p3g_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [15:0] busAddr,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [15:0] busWdata,
   input wire logic [15:0] busRdata,
   input wire logic [15:0] altOut,
   input wire logic byteHighDisable,
   input wire logic writeConfigSelect
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   logic mapped;
   assign mapped = busAddr == P3G_ADDR_DATA_LATCH || busAddr == P3G_ADDR_DIRECTION_CTL
      || busAddr == P3G_ADDR_OPEN_DRAIN_CTL;
   a_rdata_holds: assert property (!busRead |=> $stable(busRdata))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (busRead && !mapped |=> busRdata == P3G_ZERO)
      else $error("unmapped read not zero");
   a_od_gap_bits: assert property (busRead && busAddr == P3G_ADDR_OPEN_DRAIN_CTL |=>
      (busRdata & ~P3G_OPEN_DRAIN_MASK) == P3G_ZERO) else $error("open-drain gap bit set");
   a_unused_alt_high: assert property ((altOut | P3G_ALT_OUTPUT_LINES | P3G_BIDIR_LINES)
      == P3G_ALL_ONES) else $error("line without alternate output not high");
   a_strap_steady: assert property ($past(rst_n) && $past(rst_n, 2) |->
      $stable(writeConfigSelect)) else $error("strap changed after start-up");
   a_dir12_kept_low: assert property (busWrite && busAddr == P3G_ADDR_DIRECTION_CTL &&
      (!byteHighDisable || writeConfigSelect) |-> !busWdata[P3G_LINE_STROBE])
      else $error("line 12 direction set while the strobe owns it");
   a_one_strobe: assert property (!(busWrite && busRead))
      else $error("read and write together");
   a_write_mapped: assert property (busWrite |-> mapped)
      else $error("write to unmapped address");
   a_rdata_reset: assert property (disable iff (1'b0) !rst_n |=> busRdata == P3G_ZERO)
      else $error("read data not cleared by reset");
endmodule

// *** p3g_host.sv ***
/*
 Programming end: keeps the port registers in line with the wanted pin use,
 merges peripheral outputs and drives the strobe and clock-output controls.
 Assumes it is the only writer of the port registers.
*/
`timescale 1ns/10ps
module p3g_host
   import p3g_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   p3g_if.host link,
   input wire logic [15:0] gpioDir,
   input wire logic [15:0] gpioData,
   input wire logic [15:0] gpioOpenDrain,
   input wire logic [15:0] altOutEnable,
   input wire logic [15:0] altOutValue,
   input wire logic [15:0] bidirDriveOut,
   output logic [15:0] altInData,
   input wire logic clockOutOn,
   input wire logic systemClockIn,
   input wire logic byteHighDisableIn,
   input wire logic writeConfigStrap,
   input wire logic byteHighEnableIn,
   input wire logic writeHighIn,
   input wire logic busHoldIn,
   input wire logic readReq,
   input wire logic [15:0] readAddr,
   output logic [15:0] readData,
   output logic readValid,
   output logic busy
);
   p3g_host_state_t state;
   p3g_host_state_t next_state;
   logic [15:0] dirShadow;
   logic [15:0] latchShadow;
   logic [15:0] odShadow;
   logic [15:0] dirWant;
   logic [15:0] latchWant;
   logic [15:0] odWant;
   logic [15:0] rdAddr;
   logic writeConfig;
   logic strapTaken;

   // Strap caught on the first edge after reset release.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         writeConfig <= 1'b0;
         strapTaken <= 1'b0;
      end else if (!strapTaken) begin
         writeConfig <= writeConfigStrap;
         strapTaken <= 1'b1;
      end
   end

   assign link.writeConfigSelect = writeConfig;
   assign link.byteHighDisable = byteHighDisableIn;
   assign link.byteHighEnableStrobe = byteHighEnableIn;
   assign link.writeHighStrobe = writeHighIn;
   assign link.busHold = busHoldIn;
   assign link.clkOutEnable = clockOutOn;
   assign link.systemClockOutput = systemClockIn;
   assign altInData = link.altIn;
   // A peripheral not using its output leaves the line to the latch.
   assign link.altOut = (altOutValue & altOutEnable) | ~altOutEnable;

   always_comb begin
      // Alternate outputs need direction and latch set.
      dirWant = (gpioDir & ~P3G_BIDIR_LINES) | altOutEnable;
      // Two-way lines follow the peripheral's present mode.
      dirWant = dirWant | (bidirDriveOut & P3G_BIDIR_LINES);
      // Line 12 stays an input while the strobe may be handed back on hold.
      if (!byteHighDisableIn || writeConfig) begin
         dirWant[P3G_LINE_STROBE] = 1'b0;
      end
      latchWant = gpioData | altOutEnable;
      odWant = gpioOpenDrain & P3G_OPEN_DRAIN_MASK;
   end

   always_comb begin
      next_state = P3G_IDLE;
      case (state)
         P3G_IDLE: begin
            if (!strapTaken) begin
               next_state = P3G_IDLE;
            end else if (readReq) begin
               next_state = P3G_RD_ISSUE;
            end else if (latchWant != latchShadow) begin
               // Latch first, so a newly driven line never shows a stale zero.
               next_state = P3G_WR_LATCH;
            end else if (dirWant != dirShadow) begin
               next_state = P3G_WR_DIR;
            end else if (odWant != odShadow) begin
               next_state = P3G_WR_OD;
            end
         end
         P3G_RD_ISSUE: next_state = P3G_RD_TAKE;
         default: next_state = P3G_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= P3G_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         latchShadow <= P3G_RST_DATA_LATCH;
         dirShadow <= P3G_RST_DIRECTION_CTL;
         odShadow <= P3G_RST_OPEN_DRAIN_CTL;
      end else begin
         if (state == P3G_WR_LATCH) begin
            latchShadow <= latchWant;
         end
         if (state == P3G_WR_DIR) begin
            dirShadow <= dirWant;
         end
         if (state == P3G_WR_OD) begin
            odShadow <= odWant;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdAddr <= P3G_ZERO;
      end else if (state == P3G_IDLE && readReq) begin
         rdAddr <= readAddr;
      end
   end

   always_comb begin
      link.busWrite = 1'b0;
      link.busRead = 1'b0;
      link.busAddr = P3G_ZERO;
      link.busWdata = P3G_ZERO;
      case (state)
         P3G_WR_LATCH: begin
            link.busWrite = 1'b1;
            link.busAddr = P3G_ADDR_DATA_LATCH;
            link.busWdata = latchWant;
         end
         P3G_WR_DIR: begin
            link.busWrite = 1'b1;
            link.busAddr = P3G_ADDR_DIRECTION_CTL;
            link.busWdata = dirWant;
         end
         P3G_WR_OD: begin
            link.busWrite = 1'b1;
            link.busAddr = P3G_ADDR_OPEN_DRAIN_CTL;
            link.busWdata = odWant;
         end
         P3G_RD_ISSUE: begin
            link.busRead = 1'b1;
            link.busAddr = rdAddr;
         end
         default: begin
            link.busWrite = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         readData <= P3G_ZERO;
         readValid <= 1'b0;
      end else begin
         readValid <= (state == P3G_RD_TAKE);
         if (state == P3G_RD_TAKE) begin
            readData <= link.busRdata;
         end
      end
   end

   assign busy = (state != P3G_IDLE);
endmodule

// *** p3g_if.sv ***
/*
 Connection between the port block and the party that programs it and owns
 the peripherals sharing its pins. Clock and reset come from the testbench.
*/
`timescale 1ns/10ps
interface p3g_if (
   input wire logic ref_clk,
   input wire logic rst_n
);
   logic [15:0] busAddr;
   logic busWrite;
   logic busRead;
   logic [15:0] busWdata;
   logic [15:0] busRdata;
   logic [15:0] altOut;
   logic [15:0] altIn;
   logic clkOutEnable;
   logic systemClockOutput;
   logic byteHighDisable;
   logic writeConfigSelect;
   logic byteHighEnableStrobe;
   logic writeHighStrobe;
   logic busHold;

   modport device (
      input busAddr, busWrite, busRead, busWdata, altOut, clkOutEnable,
      input systemClockOutput, byteHighDisable, writeConfigSelect,
      input byteHighEnableStrobe, writeHighStrobe, busHold,
      output busRdata, altIn
   );
   modport host (
      output busAddr, busWrite, busRead, busWdata, altOut, clkOutEnable,
      output systemClockOutput, byteHighDisable, writeConfigSelect,
      output byteHighEnableStrobe, writeHighStrobe, busHold,
      input busRdata, altIn
   );
endinterface

// *** p3g_pkg.sv ***
/*
 Shared constants and types for the 16-line port with alternate functions.
 Assumes a single 100 MHz clock and a synchronous active-low reset in both ends.
*/
package p3g_pkg;
   localparam int P3G_W = 16;
   localparam logic [15:0] P3G_ADDR_DATA_LATCH = 16'hFFC4;
   localparam logic [15:0] P3G_ADDR_DIRECTION_CTL = 16'hFFC6;
   localparam logic [15:0] P3G_ADDR_OPEN_DRAIN_CTL = 16'hF1C6;
   localparam logic [15:0] P3G_RST_DATA_LATCH = 16'h0000;
   localparam logic [15:0] P3G_RST_DIRECTION_CTL = 16'h0000;
   localparam logic [15:0] P3G_RST_OPEN_DRAIN_CTL = 16'h0000;
   // Lines 15, 14 and 12 have no open-drain driver.
   localparam logic [15:0] P3G_OPEN_DRAIN_MASK = 16'h2FFF;
   localparam int P3G_LINE_STROBE = 12;
   localparam int P3G_LINE_NO_PIN = 14;
   localparam int P3G_LINE_CLOCK_OUT = 15;
   // Alternate inputs: timer 0, capture, timer 3 up/down, timer 4, 3 and 2 count.
   localparam logic [15:0] P3G_ALT_INPUT_LINES = 16'h00F5;
   // Plain alternate outputs: timer 6 toggle, timer 3 toggle, serial 0 transmit.
   localparam logic [15:0] P3G_ALT_OUTPUT_LINES = 16'h040A;
   // Two-way alternate lines: both sync serial data lines, serial 0 receive, shift clock.
   localparam logic [15:0] P3G_BIDIR_LINES = 16'h2B00;
   localparam logic [15:0] P3G_ALL_ONES = 16'hFFFF;
   localparam logic [15:0] P3G_ZERO = 16'h0000;

   typedef enum {
      P3G_IDLE,
      P3G_WR_LATCH,
      P3G_WR_DIR,
      P3G_WR_OD,
      P3G_RD_ISSUE,
      P3G_RD_TAKE
   } p3g_host_state_t;
endpackage

// *** p3g_port.sv ***
/*
 Port block: data latch, direction and open-drain registers, pin drivers and
 the alternate-function merge for fifteen pins. Assumes pads resolve the wire
 from padOut and padOe, and that padIn is asynchronous to ref_clk.
*/
`timescale 1ns/10ps
module p3g_port
   import p3g_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   p3g_if.device link,
   input wire logic [15:0] padIn,
   output logic [15:0] padOut,
   output logic [15:0] padOe
);
   logic [15:0] dirReg;
   logic [15:0] latchReg;
   logic [15:0] odReg;
   logic [15:0] padMeta;
   logic [15:0] inputLatch;
   logic [15:0] next_padOut;
   logic [15:0] next_padOe;
   logic [15:0] readValue;
   logic strobeActive;
   logic strobeOnPin;
   logic strobeValue;

   function automatic logic addrHit(input logic [15:0] addr, input logic [15:0] target);
      addrHit = (addr == target);
   endfunction

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dirReg <= P3G_RST_DIRECTION_CTL;
      end else if (link.busWrite && addrHit(link.busAddr, P3G_ADDR_DIRECTION_CTL)) begin
         dirReg <= link.busWdata;
      end
   end

   // Bit 14 is stored and read back although no pad follows it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         latchReg <= P3G_RST_DATA_LATCH;
      end else if (link.busWrite && addrHit(link.busAddr, P3G_ADDR_DATA_LATCH)) begin
         latchReg <= link.busWdata;
      end
   end

   // Bits without an open-drain driver are not stored and read as zero.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         odReg <= P3G_RST_OPEN_DRAIN_CTL;
      end else if (link.busWrite && addrHit(link.busAddr, P3G_ADDR_OPEN_DRAIN_CTL)) begin
         odReg <= link.busWdata & P3G_OPEN_DRAIN_MASK;
      end
   end

   // Two-stage input sampling; the second stage is the input latch.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         padMeta <= P3G_ZERO;
         inputLatch <= P3G_ZERO;
      end else begin
         padMeta <= padIn;
         inputLatch <= padMeta;
      end
   end

   // Every alternate input consumer sees the sampled pin state.
   assign link.altIn = inputLatch;

   // The strobe owns line 12 unless both select bits free it; their reset values
   // leave it owned, so the strobe works before any software runs.
   assign strobeActive = !link.byteHighDisable || link.writeConfigSelect;
   // Bus hold hands line 12 back to its own direction and latch bits.
   assign strobeOnPin = strobeActive && !link.busHold;
   assign strobeValue = link.writeConfigSelect ? link.writeHighStrobe
                                                : link.byteHighEnableStrobe;

   always_comb begin
      logic drive;
      logic value;
      logic openDrain;
      drive = 1'b0;
      value = 1'b0;
      openDrain = 1'b0;
      next_padOe = P3G_ZERO;
      next_padOut = P3G_ZERO;
      for (int i = 0; i < P3G_W; i++) begin
         drive = dirReg[i];
         value = latchReg[i] & link.altOut[i];
         openDrain = odReg[i] & P3G_OPEN_DRAIN_MASK[i];
         if (i == P3G_LINE_CLOCK_OUT && link.clkOutEnable) begin
            drive = 1'b1;
            value = link.systemClockOutput;
         end
         if (i == P3G_LINE_STROBE && strobeOnPin) begin
            drive = 1'b1;
            value = strobeValue;
         end
         if (i == P3G_LINE_NO_PIN) begin
            drive = 1'b0;
         end
         // An open-drain driver only ever pulls low.
         next_padOe[i] = drive && (!openDrain || !value);
         next_padOut[i] = value;
      end
   end

   // Pads are registered, so a pin follows its cause one edge later; this also
   // means the clock output toggles at most at half the system rate.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         padOe <= P3G_ZERO;
         padOut <= P3G_ZERO;
      end else begin
         padOe <= next_padOe;
         padOut <= next_padOut;
      end
   end

   // Output lines and bit 14 read their latch, other input lines read the pin.
   always_comb begin
      readValue = P3G_ZERO;
      if (addrHit(link.busAddr, P3G_ADDR_DATA_LATCH)) begin
         readValue = (latchReg & dirReg) | (inputLatch & ~dirReg);
         readValue[P3G_LINE_NO_PIN] = latchReg[P3G_LINE_NO_PIN];
      end else if (addrHit(link.busAddr, P3G_ADDR_DIRECTION_CTL)) begin
         readValue = dirReg;
      end else if (addrHit(link.busAddr, P3G_ADDR_OPEN_DRAIN_CTL)) begin
         readValue = odReg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         link.busRdata <= P3G_ZERO;
      end else if (link.busRead) begin
         link.busRdata <= readValue;
      end
   end
endmodule

// *** tb.sv ***
/*
 Testbench joining the port and host ends through the interface.
 Assumes the pins resolve from the port drivers and a bench-side external drive.
*/
`timescale 1ns/10ps
module tb
   import p3g_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] gpioDir = 16'h0000, gpioData = 16'h0000, gpioOpenDrain = 16'h0000;
   logic [15:0] altOutEnable = 16'h0000, altOutValue = 16'h0000, extDrive = 16'h0000;
   logic [15:0] readAddr = 16'h0000, padOut, padOe, altInData, readData, padIn, bidirDriveOut;
   logic clockOutOn = 1'b0, systemClockIn = 1'b0, byteHighDisableIn = 1'b0;
   logic writeConfigStrap = 1'b0, byteHighEnableIn = 1'b0, writeHighIn = 1'b0;
   logic busHoldIn = 1'b0, readReq = 1'b0, readValid, busy;
   int num_errors = 0;
   int checked = 0;
   integer seed = 60479;
   always #5 ref_clk = ~ref_clk;
   // Undriven lines follow the bench's external drive, so a float is never read as a hit.
   assign padIn = (padOe & padOut) | (~padOe & extDrive);
   // Two-way lines take the direction that the peripheral's mode wants.
   assign bidirDriveOut = gpioDir & P3G_BIDIR_LINES;
   p3g_if link (.ref_clk(ref_clk), .rst_n(rst_n));
   p3g_port p3g_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .padIn(padIn),
      .padOut(padOut), .padOe(padOe));
   p3g_host p3g_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .gpioDir(gpioDir),
      .gpioData(gpioData), .gpioOpenDrain(gpioOpenDrain), .altOutEnable(altOutEnable),
      .altOutValue(altOutValue), .bidirDriveOut(bidirDriveOut), .altInData(altInData),
      .clockOutOn(clockOutOn), .systemClockIn(systemClockIn),
      .byteHighDisableIn(byteHighDisableIn), .writeConfigStrap(writeConfigStrap),
      .byteHighEnableIn(byteHighEnableIn), .writeHighIn(writeHighIn), .busHoldIn(busHoldIn),
      .readReq(readReq), .readAddr(readAddr), .readData(readData), .readValid(readValid),
      .busy(busy));
   p3g_assertions p3g_assertions_inst (.ref_clk(ref_clk), .rst_n(rst_n),
      .busAddr(link.busAddr), .busWrite(link.busWrite), .busRead(link.busRead),
      .busWdata(link.busWdata), .busRdata(link.busRdata), .altOut(link.altOut),
      .byteHighDisable(link.byteHighDisable), .writeConfigSelect(link.writeConfigSelect));

   // Only the low half of each draw is used, so no bits are dropped silently.
   function automatic logic [15:0] rnd16();
      logic [31:0] r;
      r = $random(seed);
      return r[15:0];
   endfunction

   function automatic logic [15:0] exp_dir();
      logic [15:0] d;
      d = gpioDir | altOutEnable;
      if (!byteHighDisableIn || writeConfigStrap) d[P3G_LINE_STROBE] = 1'b0;
      return d;
   endfunction

   function automatic logic [31:0] exp_pads();
      logic [15:0] d, v, od;
      d = exp_dir();
      v = (gpioData | altOutEnable) & (altOutValue | ~altOutEnable);
      od = gpioOpenDrain & P3G_OPEN_DRAIN_MASK;
      d = d & ~(od & v);
      if (clockOutOn) begin
         d[P3G_LINE_CLOCK_OUT] = 1'b1;
         v[P3G_LINE_CLOCK_OUT] = systemClockIn;
      end
      if ((!byteHighDisableIn || writeConfigStrap) && !busHoldIn) begin
         d[P3G_LINE_STROBE] = 1'b1;
         v[P3G_LINE_STROBE] = writeConfigStrap ? writeHighIn : byteHighEnableIn;
      end
      d[P3G_LINE_NO_PIN] = 1'b0;
      return {d, v & d};
   endfunction

   function automatic logic [15:0] exp_pin();
      logic [31:0] e;
      e = exp_pads();
      return e[15:0] | (extDrive & ~e[31:16]);
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] want, input string what);
      checked++;
      if (got !== want) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask

   task automatic check_pads();
      int n;
      logic [31:0] e;
      repeat (3) begin
         repeat (2) @(negedge ref_clk);
         n = 0;
         while (busy !== 1'b0 && n < 40) begin
            @(negedge ref_clk);
            n++;
         end
      end
      repeat (4) @(negedge ref_clk);
      e = exp_pads();
      cmp(padOe, e[31:16], "pin enable");
      cmp(padOut & padOe, e[15:0], "pin value");
      cmp(altInData, exp_pin(), "input latch");
   endtask

   task automatic rd(input logic [15:0] a, input logic [15:0] want, input string what);
      int n;
      readAddr = a;
      readReq = 1'b1;
      n = 0;
      while (readValid !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      readReq = 1'b0;
      cmp({15'h0000, readValid}, 16'h0001, "read answer");
      cmp(readData, want, what);
      @(negedge ref_clk);
   endtask

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #300000;
      num_errors++;
      close_out();
   end

   initial begin
      logic [15:0] d;
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      byteHighEnableIn = 1'b1;
      check_pads();
      rd(P3G_ADDR_DIRECTION_CTL, P3G_RST_DIRECTION_CTL, "direction reset");
      rd(P3G_ADDR_OPEN_DRAIN_CTL, P3G_RST_OPEN_DRAIN_CTL, "open-drain reset");
      rd(16'h1234, P3G_ZERO, "unmapped read");
      gpioDir = 16'h1000;
      gpioData = 16'h1000;
      busHoldIn = 1'b1;
      check_pads();
      busHoldIn = 1'b0;
      $display("test strobe finished");
      byteHighDisableIn = 1'b1;
      for (int i = 0; i < 30; i++) begin
         // Direction bit 14 is drawn too, so a driver on the missing pin would show.
         gpioDir = (i == 0) ? P3G_ALL_ONES : rnd16();
         gpioData = (i == 0) ? P3G_ALL_ONES : rnd16();
         gpioOpenDrain = (i == 0) ? P3G_ALL_ONES : rnd16();
         altOutEnable = (i == 1) ? P3G_ALT_OUTPUT_LINES : rnd16() & P3G_ALT_OUTPUT_LINES;
         altOutValue = rnd16();
         extDrive = rnd16();
         clockOutOn = i[0];
         d = rnd16();
         systemClockIn = d[0];
         check_pads();
         d = exp_dir();
         rd(P3G_ADDR_DIRECTION_CTL, d, "direction read");
         rd(P3G_ADDR_OPEN_DRAIN_CTL, gpioOpenDrain & P3G_OPEN_DRAIN_MASK, "od read");
         d[P3G_LINE_NO_PIN] = 1'b1;
         rd(P3G_ADDR_DATA_LATCH, ((gpioData | altOutEnable) & d) | (exp_pin() & ~d),
            "latch read");
      end
      $display("test random port finished");
      rst_n = 1'b0;
      writeConfigStrap = 1'b1;
      repeat (8) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         writeHighIn = i[0];
         byteHighEnableIn = ~i[0];
         check_pads();
      end
      $display("test write strobe finished");
      close_out();
   end
endmodule
